// ---- common/gpio_cmd_pkg.sv ----
package gpio_cmd_pkg;
    localparam int FRAME_BYTES = 9;
    localparam int PARAM_BYTES = 4;
    localparam int RESP_BYTES = 5;
    localparam int PARAM_BITS = 32;
    localparam logic [3:0] LAST_RX_IDX = 4'h8;
    localparam logic [2:0] RESP_LEN_OK = 3'h5;
    localparam logic [2:0] RESP_LEN_ERR = 3'h1;
    localparam logic [7:0] CMD_GET_FUNC = 8'h10;
    localparam logic [7:0] CMD_GET_DIR = 8'h11;
    localparam logic [7:0] CMD_GET_LVL = 8'h12;
    localparam logic [7:0] CMD_GET_STATE = 8'h13;
    localparam logic [7:0] CMD_SET_DIR = 8'h19;
    localparam logic [7:0] CMD_SET_LVL = 8'h1a;
    localparam logic [7:0] CMD_SET_STATE = 8'h1b;
    localparam logic [7:0] ERR_BYTE = 8'hff;
    localparam logic RST_DIR = 1'b0;
    localparam logic RST_LVL = 1'b1;
    localparam logic RST_STATE = 1'b0;
    typedef enum logic [1:0] {FLD_DIR, FLD_LVL, FLD_STATE} field_t;
endpackage

// ---- common/pin_bank_if.sv ----
interface pin_bank_if #(parameter int NPINS = 11);
    import gpio_cmd_pkg::*;
    logic wr;
    field_t sel;
    logic [NPINS-1:0] mask;
    logic [NPINS-1:0] value;
    logic [NPINS-1:0] func;
    logic [NPINS-1:0] dir;
    logic [NPINS-1:0] lvl;
    logic [NPINS-1:0] state;
    modport ctrl (output wr, sel, mask, value, func, input dir, lvl, state);
    modport bank (input wr, sel, mask, value, func, output dir, lvl, state);
endinterface

// ---- design/pin_bank.sv ----
module pin_bank
    import gpio_cmd_pkg::*;
#(
    parameter int NPINS = 11
)(
    input wire logic clk,
    input wire logic srst,
    pin_bank_if.bank bus,
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe
);
    logic [NPINS-1:0] dir_q, lvl_q, st_q, sync1_q, sync2_q, out_q, oe_q;
    logic [NPINS-1:0] dir_d, lvl_d, st_d, st_mask;

    // Masked update: only selected bits take the new value
    assign st_mask = bus.mask & dir_q;
    assign dir_d = (bus.wr && bus.sel == FLD_DIR) ? ((dir_q & ~bus.mask) | (bus.value & bus.mask)) : dir_q;
    assign lvl_d = (bus.wr && bus.sel == FLD_LVL) ? ((lvl_q & ~bus.mask) | (bus.value & bus.mask)) : lvl_q;
    assign st_d = (bus.wr && bus.sel == FLD_STATE) ? ((st_q & ~st_mask) | (bus.value & st_mask)) : st_q;

    // Live settings only; reset brings back the defaults
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            dir_q <= {NPINS{RST_DIR}};
            lvl_q <= {NPINS{RST_LVL}};
            st_q <= {NPINS{RST_STATE}};
            out_q <= '0;
            oe_q <= '0;
        end
        else
        begin
            dir_q <= dir_d;
            lvl_q <= lvl_d;
            st_q <= st_d;
            out_q <= st_q ^ lvl_q;
            oe_q <= dir_q & bus.func;
        end
    end

    always_ff @(posedge clk)
    begin
        sync1_q <= pin_in;
        sync2_q <= sync1_q;
    end

    assign pin_out = out_q;
    assign pin_oe = oe_q;
    assign bus.dir = dir_q;
    assign bus.lvl = lvl_q;
    assign bus.state = (dir_q & st_q) | (~dir_q & (sync2_q ^ lvl_q));

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    reset_default_a: assert property ($past(srst) |-> dir_q == '0 && lvl_q == '1)
        else $error("pin defaults wrong after reset");
    input_state_kept_a: assert property (bus.wr && bus.sel == FLD_STATE |=>
        ((st_q ^ $past(st_q)) & ~$past(dir_q)) == '0)
        else $error("state write changed an input pin");
    dir_mask_a: assert property (bus.wr && bus.sel == FLD_DIR |=>
        ((dir_q ^ $past(dir_q)) & ~$past(bus.mask)) == '0)
        else $error("direction changed outside mask");
    drive_level_a: assert property (!$past(srst) |-> out_q == $past(st_q ^ lvl_q))
        else $error("pin level does not follow state and polarity");
endmodule // pin_bank

// ---- design/gpio_cmd.sv ----
// How it works
// - After reset pins are GPIO inputs, active low.
// - A command frame is nine bytes: command then two four-byte parameters.
// - Parameters are little-endian; pin 0 is bit 0 of the first byte.
// - Bits of non-GPIO pins read as anything and are ignored on writes.
// - A valid command returns five bytes: echoed command plus one parameter.
// - An invalid command returns one byte 0xff and changes nothing.
// - Codes 10h-13h read func/dir/level/state; 19h-1Bh set dir/level/state.
// - Pin function cannot be written here; it is read only.
// - Set values are live only and revert at reset.
// - Unused parameters are ignored; reads still take the full frame.
// - Function bit 1 means user GPIO, 0 means dedicated function.
// - Direction bit 1 is output, 0 is input.
// - Level bit 1 is active low, 0 is active high.
// - Only the eleven configurable pins exist; higher bits unused.
// - A disable setting stops the service; no command is accepted.
// - Set directions uses parameter one as mask, parameter two as values.
// - State bit 1 means active, through the active-level setting.
module gpio_cmd
    import gpio_cmd_pkg::*;
#(
    parameter int NPINS = 11
)(
    input wire logic clk,
    input wire logic srst,
    input wire logic service_disable,
    input wire logic [NPINS-1:0] pin_func,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe
);
    generate
        if (NPINS < 1 || NPINS > PARAM_BITS)
        begin : g_bad_npins
            $error("NPINS must be 1 to 32");
        end
    endgenerate

    typedef enum logic [1:0] {S_RX, S_EXEC, S_LOAD, S_TX} state_t;

    state_t state_q, state_d;
    logic [3:0] cnt_q;
    logic [7:0] cmd_q;
    logic [PARAM_BITS-1:0] p1_q, p2_q;
    logic [8*RESP_BYTES-1:0] tx_buf_q;
    logic [2:0] tx_left_q;

    pin_bank_if #(.NPINS(NPINS)) bank_bus ();

    pin_bank #(.NPINS(NPINS)) u_bank (
        .clk(clk),
        .srst(srst),
        .bus(bank_bus),
        .pin_in(pin_in),
        .pin_out(pin_out),
        .pin_oe(pin_oe)
    );

    wire rx_take = rx_valid && rx_ready;
    wire tx_take = tx_valid && tx_ready;
    wire frame_done = rx_take && !service_disable && cnt_q == LAST_RX_IDX;
    wire tx_last = tx_take && tx_left_q == RESP_LEN_ERR;

    // Command decode
    wire is_get = cmd_q == CMD_GET_FUNC || cmd_q == CMD_GET_DIR
        || cmd_q == CMD_GET_LVL || cmd_q == CMD_GET_STATE;
    wire is_set = cmd_q == CMD_SET_DIR || cmd_q == CMD_SET_LVL || cmd_q == CMD_SET_STATE;
    wire valid_cmd = is_get || is_set;
    wire field_t set_sel = (cmd_q == CMD_SET_DIR) ? FLD_DIR : (cmd_q == CMD_SET_LVL) ? FLD_LVL : FLD_STATE;

    // Readback after any update; bits above NPINS read zero
    wire [NPINS-1:0] rd_pins = (cmd_q == CMD_GET_FUNC) ? pin_func
        : (cmd_q == CMD_GET_DIR || cmd_q == CMD_SET_DIR) ? bank_bus.dir
        : (cmd_q == CMD_GET_LVL || cmd_q == CMD_SET_LVL) ? bank_bus.lvl
        : bank_bus.state;
    wire [PARAM_BITS-1:0] rd_word = PARAM_BITS'(rd_pins);

    // Non-GPIO bits never reach the bank; parameters of reads are dropped
    assign bank_bus.wr = state_q == S_EXEC && is_set && !service_disable;
    assign bank_bus.sel = set_sel;
    assign bank_bus.mask = p1_q[NPINS-1:0] & pin_func;
    assign bank_bus.value = p2_q[NPINS-1:0];
    assign bank_bus.func = pin_func;

    assign rx_ready = state_q == S_RX;
    assign tx_valid = state_q == S_TX;
    assign tx_data = tx_buf_q[7:0];

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            S_RX: if (frame_done) state_d = S_EXEC;
            S_EXEC: state_d = S_LOAD;
            S_LOAD: state_d = S_TX;
            S_TX: if (tx_last) state_d = S_RX;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            state_q <= S_RX;
        else
            state_q <= state_d;
    end

    // Frame capture; a disable drops any partial frame
    always_ff @(posedge clk)
    begin
        if (srst || (state_q == S_RX && service_disable))
            cnt_q <= '0;
        else if (rx_take)
            cnt_q <= (cnt_q == LAST_RX_IDX) ? 4'h0 : cnt_q + 4'h1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cmd_q <= '0;
            p1_q <= '0;
            p2_q <= '0;
        end
        else if (rx_take && !service_disable)
        begin
            if (cnt_q == 4'h0)
                cmd_q <= rx_data;
            else if (cnt_q <= 4'(PARAM_BYTES))
                p1_q <= {rx_data, p1_q[PARAM_BITS-1:8]};
            else
                p2_q <= {rx_data, p2_q[PARAM_BITS-1:8]};
        end
    end

    // Response shifter, least significant byte first
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            tx_buf_q <= '0;
            tx_left_q <= '0;
        end
        else if (state_q == S_LOAD)
        begin
            tx_buf_q <= valid_cmd ? {rd_word, cmd_q} : {32'h0, ERR_BYTE};
            tx_left_q <= valid_cmd ? RESP_LEN_OK : RESP_LEN_ERR;
        end
        else if (tx_take)
        begin
            tx_buf_q <= {8'h00, tx_buf_q[8*RESP_BYTES-1:8]};
            tx_left_q <= tx_left_q - 3'h1;
        end
    end

    localparam logic [PARAM_BITS-1:0] USED_BITS = PARAM_BITS'({NPINS{1'b1}});

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    err_byte_a: assert property (state_q == S_LOAD && !valid_cmd |=>
        tx_valid && tx_data == ERR_BYTE && tx_left_q == RESP_LEN_ERR)
        else $error("invalid command not answered with single error byte");
    echo_cmd_a: assert property (state_q == S_LOAD && valid_cmd |=>
        tx_valid && tx_data == $past(cmd_q) && tx_left_q == RESP_LEN_OK)
        else $error("valid command not echoed in five byte answer");
    no_bad_write_a: assert property (bank_bus.wr |-> $past(frame_done) && cmd_q != CMD_GET_FUNC)
        else $error("bank written by a non-set command");
    disable_hold_a: assert property (service_disable && state_q == S_RX |=>
        state_q == S_RX && cnt_q == 4'h0)
        else $error("command accepted while service disabled");
    frame_len_a: assert property (frame_done |=> state_q == S_EXEC ##1 state_q == S_LOAD)
        else $error("ninth byte did not start execution");
    mask_func_a: assert property (bank_bus.wr |-> (bank_bus.mask & ~pin_func) == '0)
        else $error("write reached a non-GPIO pin");
    high_bits_a: assert property (state_q == S_LOAD && valid_cmd |=>
        (tx_buf_q[8*RESP_BYTES-1:8] & ~USED_BITS) == '0)
        else $error("unused pin bits not zero");
    next_cmd_a: assert property (tx_last |=> rx_ready && !tx_valid)
        else $error("not ready for next command after answer");
    wait_resp_a: assert property (frame_done |=> !rx_ready [*3])
        else $error("took bytes before answering");

    set_cmd_c: cover property (bank_bus.wr ##[1:16] tx_last);
    get_cmd_c: cover property (state_q == S_LOAD && is_get);
    err_cmd_c: cover property (state_q == S_LOAD && !valid_cmd);
    disabled_c: cover property (service_disable && rx_take);
endmodule // gpio_cmd

// ---- testbench/host_model.sv ----
module host_model
    import gpio_cmd_pkg::*;
(
    input wire logic clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    bit slow = 1'b0;
    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
    end
    // One byte is held until the edge at which it is taken
    task automatic put_byte(input logic [7:0] b, output bit ok);
        int w;
        @(negedge clk);
        rx_valid = 1'b1;
        rx_data = b;
        for (w = 0; w < 64 && rx_ready !== 1'b1; w++)
            @(negedge clk);
        ok = (rx_ready === 1'b1);
        @(posedge clk);
    endtask
    task automatic send(input logic [7:0] c, input logic [31:0] a, input logic [31:0] b, input int n,
                        output logic [39:0] r, output bit ok);
        logic [71:0] f;
        bit k;
        int i;
        int w;
        f = {b, a, c};
        ok = 1'b1;
        r = '0;
        for (i = 0; i < 9; i++)
        begin
            put_byte(f[8*i +: 8], k);
            ok &= k;
        end
        @(negedge clk);
        rx_valid = 1'b0;
        rx_data = ~f[71:64];
        // Whole answer is drained before the caller may send again
        for (i = 0; i < n; i++)
        begin
            for (w = 0; w < 64 && tx_valid !== 1'b1; w++)
                @(negedge clk);
            // Ready stays high between bytes unless a stall is asked for
            if (slow)
            begin
                tx_ready = 1'b0;
                repeat (3) @(negedge clk);
            end
            ok &= (tx_valid === 1'b1);
            r[8*i +: 8] = tx_data;
            tx_ready = 1'b1;
            @(negedge clk);
        end
        tx_ready = 1'b0;
    endtask
endmodule // host_model

// ---- testbench/gpio_cmd_tb_top.sv ----
module gpio_cmd_tb_top
    import gpio_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] c; logic [31:0] a; logic [31:0] b; int n; logic [31:0] e;} row_t;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic service_disable = 1'b0;
    logic [10:0] pin_func = 11'h7fb;
    logic [10:0] pin_in = 11'h0f0;
    logic [10:0] pin_out, pin_oe;
    logic rx_valid, rx_ready, tx_valid, tx_ready;
    logic [7:0] rx_data, tx_data;
    int err_total = 0;
    int n_compared = 0;
    int q;
    row_t rows[12] = '{
        '{8'h10, 32'hffffffff, 32'hffffffff, 5, 32'h7fb}, '{8'h11, 0, 0, 5, 32'h000},
        '{8'h12, 0, 0, 5, 32'h7ff}, '{8'h13, 0, 0, 5, 32'h70f},
        '{8'h19, 32'hffff00ff, 32'hffffff0f, 5, 32'h00b}, '{8'h1a, 32'h3, 32'hfffffffd, 5, 32'h7fd},
        '{8'h1b, 32'hffffffff, 32'h15, 5, 32'h701}, '{8'h12, 0, 0, 5, 32'h7fd},
        '{8'h20, 32'hffffffff, 32'hffffffff, 1, 0}, '{8'h18, 32'hffffffff, 32'hffffffff, 1, 0},
        '{8'h11, 0, 0, 5, 32'h00b}, '{8'h13, 0, 0, 5, 32'h701}};
    gpio_cmd #(.NPINS(11)) u_gpio_cmd (.clk(clk), .srst(srst), .service_disable(service_disable),
        .pin_func(pin_func), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe));
    host_model u_host_model (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    initial
    begin
        forever #4 clk = ~clk;
    end
    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bits of dedicated pins may read as anything, so they are masked out except in function reads
    task automatic run(input row_t t, input string what);
        logic [39:0] r;
        logic [31:0] m;
        bit ok;
        m = (t.c == CMD_GET_FUNC) ? 32'hffffffff : 32'h7fb;
        u_host_model.send(t.c, t.a, t.b, t.n, r, ok);
        check({what, " handshake"}, 32'h1, {31'h0, ok});
        if (t.n == 1)
            check({what, " error"}, 32'hff, {24'h0, r[7:0]});
        if (t.n == 5)
            check({what, " echo"}, {24'h0, t.c}, {24'h0, r[7:0]});
        if (t.n == 5)
            check({what, " value"}, t.e & m, r[39:8] & m);
        $display("done %s", what);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("BAD watchdog expected finish seen hang");
        test_done();
    end
    initial
    begin
        repeat (16) @(negedge clk);
        srst = 1'b0;
        check("reset ready", 32'h1, {31'h0, rx_ready});
        check("reset oe", 32'h0, {20'h0, tx_valid, pin_oe});
        $display("done reset");
        foreach (rows[i])
            run(rows[i], $sformatf("row %0d", i));
        repeat (3) @(negedge clk);
        check("pin_oe", 32'h00b, {21'h0, pin_oe});
        check("pin_out", 32'h008, {21'h0, pin_out & 11'h00b});
        u_host_model.slow = 1'b1;
        run(rows[7], "stalled read");
        u_host_model.slow = 1'b0;
        service_disable = 1'b1;
        run('{8'h19, 32'h7ff, 32'h7ff, 0, 0}, "disabled set");
        q = 0;
        repeat (20)
        begin
            @(negedge clk);
            q += (tx_valid !== 1'b0);
        end
        check("disabled quiet", 32'h0, q);
        service_disable = 1'b0;
        run(rows[10], "after disable");
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        repeat (2) @(negedge clk);
        check("rereset oe", 32'h0, {21'h0, pin_oe});
        run(rows[1], "rereset dir");
        run(rows[2], "rereset level");
        test_done();
    end
endmodule // gpio_cmd_tb_top
